/* shared/acc_pkg.sv */
// package: offsets, fields, reset values and state types of the conversion config block
package acc_pkg;
  localparam logic [11:0] ACC_OFF_CTRL = 12'h008;
  localparam logic [11:0] ACC_OFF_CFG1 = 12'h00C;
  localparam logic [11:0] ACC_OFF_CHSEL = 12'h028;
  localparam logic [11:0] ACC_OFF_DATA = 12'h040;
  localparam logic [31:0] ACC_CFG1_RST = 32'h0000_0000;
  localparam logic [31:0] ACC_CFG1_WMASK = 32'h7CC1_FDFF;
  localparam int ACC_CTRL_START = 2;
  localparam int ACC_B_DMA_EN = 0;
  localparam int ACC_B_DMA_CIRC = 1;
  localparam int ACC_B_DIR = 2;
  localparam int ACC_B_RES = 3;
  localparam int ACC_B_LEFT = 5;
  localparam int ACC_B_TSEL = 6;
  localparam int ACC_B_EDGE = 10;
  localparam int ACC_B_OVR = 12;
  localparam int ACC_B_CONT = 13;
  localparam int ACC_B_WAIT = 14;
  localparam int ACC_B_AOFF = 15;
  localparam int ACC_B_DISC = 16;
  localparam int ACC_B_AWD_ONE = 22;
  localparam int ACC_B_AWD_EN = 23;
  localparam int ACC_B_AWD_CH = 26;
  localparam int ACC_NUM_CH = 18;
  localparam logic [4:0] ACC_AWD_CH_MAX = 5'h12;
  localparam logic [1:0] ACC_EDGE_OFF = 2'b00;
  localparam logic [1:0] ACC_EDGE_RISE = 2'b01;
  localparam logic [1:0] ACC_EDGE_FALL = 2'b10;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_ARM = 2'b01,
    ACC_WAKE = 2'b10,
    ACC_CONV = 2'b11
  } acc_fsm_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } acc_apb_req_t;

  typedef struct packed {
    logic [31:0] cfg;
    logic start;
    logic [ACC_NUM_CH-1:0] chsel;
    logic [15:0] data;
    logic data_valid;
    acc_fsm_t fsm;
    logic [4:0] chan;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] trg_q;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic sample_req;
    logic power_on;
    logic dma_req;
    logic dma_circ;
    logic awd_check;
    logic overrun;
  } acc_state_t;
endpackage

/* rtl/acc_conv_cfg.sv */
// conversion configuration register with its scan sequencer and APB slave
// Notes on behaviour
// RULE1: DMA requests only while DMA enabled
// RULE2: circular bit picks DMA mode when enabled
// RULE3: scan direction ascending or descending
// RULE4: two-bit resolution 12, 10, 8, 6
// RULE5: result right or left aligned
// RULE6: three bits choose one of eight triggers
// RULE7: edge code 00 means software start only
// RULE8: rising, falling or both trigger edges
// RULE9: overrun keeps old or newest result
// RULE10: single or continuous conversion
// RULE11: wait mode holds until result read
// RULE12: auto power-off only when bit set
// RULE13: discontinuous mode only when bit set
// RULE14: watchdog compares only when enabled
// RULE15: watchdog on all or one channel
// RULE16: watchdog channel code 0 to 18
// RULE17: software also selects the watchdog channel
// RULE18: configuration writable only while start clear
// RULE19: configuration resets to zero
// RULE20: power down idle, wake on start
// RULE21: start set by software, cleared by hardware
// RULE22: only selected channels are converted
// RULE23: reserved bits read zero, ignore writes
// RULE24: trigger synchronised, one edge one start
`timescale 1ns/10ps
module acc_conv_cfg (
  input wire logic clk_sys,
  input wire logic rst,
  input wire acc_pkg::acc_apb_req_t apb_req,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic [7:0] ext_trig,
  input wire logic adc_done,
  input wire logic [11:0] adc_raw,
  output logic adc_sample_req,
  output logic [4:0] adc_channel,
  output logic adc_power_on,
  output logic dma_req,
  output logic dma_circular,
  output logic awd_check,
  output logic overrun
);
  acc_pkg::acc_state_t s;
  acc_pkg::acc_state_t n;

  // next selected channel in scan order; bit 5 flags a hit
  function automatic logic [5:0] acc_next_ch(input logic [acc_pkg::ACC_NUM_CH-1:0] m,
                                             input logic [4:0] c, input logic dn,
                                             input logic incl);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < acc_pkg::ACC_NUM_CH; i++) begin
      if (dn && m[i] && (i < int'(c) || (incl && i == int'(c)))) begin
        r = {1'b1, 5'(i)};
      end
      if (!dn && m[acc_pkg::ACC_NUM_CH-1-i] &&
          (acc_pkg::ACC_NUM_CH-1-i > int'(c) ||
           (incl && acc_pkg::ACC_NUM_CH-1-i == int'(c)))) begin
        r = {1'b1, 5'(acc_pkg::ACC_NUM_CH-1-i)};
      end
    end
    return r;
  endfunction

  logic [1:0] edge_sel;
  logic [2:0] tsel;
  logic dir;
  logic trg_hit;
  logic [7:0] trg_new;
  logic [5:0] first_ch;
  logic [5:0] next_ch;
  logic [15:0] result;
  logic wr_acc;
  logic rd_acc;
  logic [11:0] addr;

  always_comb begin
    edge_sel = s.cfg[acc_pkg::ACC_B_EDGE +: 2];
    tsel = s.cfg[acc_pkg::ACC_B_TSEL +: 3];
    dir = s.cfg[acc_pkg::ACC_B_DIR];
    addr = apb_req.paddr[11:0];
    wr_acc = apb_req.psel && apb_req.penable && s.pready && apb_req.pwrite;
    rd_acc = apb_req.psel && apb_req.penable && s.pready && !apb_req.pwrite;
    first_ch = acc_next_ch(s.chsel, dir ? 5'h11 : 5'h00, dir, 1'b1);
    next_ch = acc_next_ch(s.chsel, s.chan, dir, 1'b0);
    // RULE24: stable after sync
    trg_new = s.trg_q;
    if (s.sync2[tsel] == s.sync3[tsel]) begin
      trg_new[tsel] = s.sync3[tsel];
    end
    // RULE8: edge polarity choice
    case (edge_sel)
      acc_pkg::ACC_EDGE_RISE: trg_hit = !s.trg_q[tsel] && trg_new[tsel];
      acc_pkg::ACC_EDGE_FALL: trg_hit = s.trg_q[tsel] && !trg_new[tsel];
      acc_pkg::ACC_EDGE_OFF: trg_hit = 1'b0;
      default: trg_hit = s.trg_q[tsel] != trg_new[tsel];
    endcase
    // RULE4: resolution drops low bits
    // RULE5: alignment within 16 bits
    result = s.cfg[acc_pkg::ACC_B_LEFT] ?
             {adc_raw & (12'hFFF << {s.cfg[acc_pkg::ACC_B_RES +: 2], 1'b0}), 4'h0} :
             {4'h0, adc_raw >> {s.cfg[acc_pkg::ACC_B_RES +: 2], 1'b0}};
  end

  always_comb begin
    n = s;
    n.sync1 = ext_trig;
    n.sync2 = s.sync1;
    n.sync3 = s.sync2;
    // RULE6: selected trigger tracked
    n.trg_q = trg_new;
    n.sample_req = 1'b0;
    n.dma_req = 1'b0;
    n.awd_check = 1'b0;
    n.overrun = 1'b0;
    n.pready = apb_req.psel && !apb_req.penable;
    n.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      case (addr)
        acc_pkg::ACC_OFF_CTRL: n.prdata = {29'h0, s.start, 2'h0};
        // RULE23: reserved read zero
        acc_pkg::ACC_OFF_CFG1: n.prdata = s.cfg & acc_pkg::ACC_CFG1_WMASK;
        acc_pkg::ACC_OFF_CHSEL: n.prdata = {14'h0, s.chsel};
        acc_pkg::ACC_OFF_DATA: n.prdata = {16'h0, s.data};
        default: begin
          n.prdata = 32'h0000_0000;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (rd_acc && addr == acc_pkg::ACC_OFF_DATA) begin
      n.data_valid = 1'b0;
    end
    if (wr_acc && !s.start) begin
      // RULE18: writes only while idle
      if (addr == acc_pkg::ACC_OFF_CFG1) begin
        n.cfg = apb_req.pwdata & acc_pkg::ACC_CFG1_WMASK;
      end
      if (addr == acc_pkg::ACC_OFF_CHSEL) begin
        n.chsel = apb_req.pwdata[acc_pkg::ACC_NUM_CH-1:0];
      end
      // RULE21: software sets start
      if (addr == acc_pkg::ACC_OFF_CTRL && apb_req.pwdata[acc_pkg::ACC_CTRL_START]) begin
        n.start = 1'b1;
      end
    end
    // RULE2: circular only with DMA on
    n.dma_circ = s.cfg[acc_pkg::ACC_B_DMA_EN] && s.cfg[acc_pkg::ACC_B_DMA_CIRC];
    case (s.fsm)
      acc_pkg::ACC_IDLE: begin
        if (s.start) begin
          n.fsm = acc_pkg::ACC_ARM;
          n.chan = first_ch[4:0];
        end
      end
      acc_pkg::ACC_ARM: begin
        // RULE7: software start only
        if (edge_sel == acc_pkg::ACC_EDGE_OFF || trg_hit) begin
          n.fsm = acc_pkg::ACC_WAKE;
        end
      end
      acc_pkg::ACC_WAKE: begin
        // RULE22: nothing selected ends
        if (!s.chsel[s.chan]) begin
          n.fsm = acc_pkg::ACC_IDLE;
          n.start = 1'b0;
        // RULE11: wait for read
        end else if (s.power_on &&
                     !(s.cfg[acc_pkg::ACC_B_WAIT] && s.data_valid)) begin
          n.sample_req = 1'b1;
          n.fsm = acc_pkg::ACC_CONV;
        end
      end
      acc_pkg::ACC_CONV: begin
        if (adc_done) begin
          // RULE9: overrun result policy
          if (s.data_valid && n.data_valid) begin
            n.overrun = 1'b1;
            if (s.cfg[acc_pkg::ACC_B_OVR]) begin
              n.data = result;
            end
          end else begin
            n.data = result;
          end
          n.data_valid = 1'b1;
          // RULE1: requests need enable
          n.dma_req = s.cfg[acc_pkg::ACC_B_DMA_EN];
          // RULE14: watchdog gate
          // RULE15: all or one channel
          // RULE16: channel code compare
          n.awd_check = s.cfg[acc_pkg::ACC_B_AWD_EN] &&
                        (!s.cfg[acc_pkg::ACC_B_AWD_ONE] ||
                         s.cfg[acc_pkg::ACC_B_AWD_CH +: 5] == s.chan);
          // RULE3: scan order step
          if (next_ch[5]) begin
            n.chan = next_ch[4:0];
            // RULE13: one channel per trigger
            n.fsm = s.cfg[acc_pkg::ACC_B_DISC] ? acc_pkg::ACC_ARM : acc_pkg::ACC_WAKE;
          // RULE10: continuous restarts
          end else if (s.cfg[acc_pkg::ACC_B_CONT]) begin
            n.chan = first_ch[4:0];
            n.fsm = s.cfg[acc_pkg::ACC_B_DISC] ? acc_pkg::ACC_ARM : acc_pkg::ACC_WAKE;
          end else begin
            // RULE21: hardware clears start
            n.start = 1'b0;
            n.fsm = acc_pkg::ACC_IDLE;
          end
        end
      end
      default: n.fsm = acc_pkg::ACC_IDLE;
    endcase
    // RULE12: auto-off gate
    // RULE20: off when not converting
    n.power_on = !s.cfg[acc_pkg::ACC_B_AOFF] ||
                 n.fsm == acc_pkg::ACC_WAKE || n.fsm == acc_pkg::ACC_CONV;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s <= '0;
      // RULE19: zero reset
      s.cfg <= acc_pkg::ACC_CFG1_RST;
      s.fsm <= acc_pkg::ACC_IDLE;
      s.power_on <= 1'b1;
    end else begin
      s <= n;
    end
  end

  always_comb begin
    pready = s.pready;
    pslverr = s.pslverr;
    prdata = s.prdata;
    adc_sample_req = s.sample_req;
    adc_channel = s.chan;
    adc_power_on = s.power_on;
    dma_req = s.dma_req;
    dma_circular = s.dma_circ;
    awd_check = s.awd_check;
    overrun = s.overrun;
  end

  // helper: last sampled channel within a sequence
  logic [4:0] prev_ch_r;
  logic prev_ok_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_ch_r <= 5'h00;
      prev_ok_r <= 1'b0;
    end else begin
      if (s.sample_req) begin
        prev_ch_r <= s.chan;
        prev_ok_r <= 1'b1;
      end
      if (s.fsm == acc_pkg::ACC_IDLE || (s.fsm == acc_pkg::ACC_CONV && adc_done &&
          !next_ch[5])) begin
        prev_ok_r <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_DMA_GATE: assert property (dma_req |-> $past(s.cfg[acc_pkg::ACC_B_DMA_EN])) // RULE1
    else $error("dma request without enable");
  AST_SCAN_UP: assert property (adc_sample_req && prev_ok_r && !dir |-> s.chan > prev_ch_r) // RULE3
    else $error("ascending scan out of order");
  AST_SCAN_DN: assert property (adc_sample_req && prev_ok_r && dir |-> s.chan < prev_ch_r) // RULE3
    else $error("descending scan out of order");
  AST_CH_SELECTED: assert property (adc_sample_req |-> s.chsel[adc_channel]) // RULE22
    else $error("unselected channel sampled");
  AST_CFG_LOCK: assert property (s.start && $past(s.start) |-> $stable(s.cfg)) // RULE18
    else $error("config changed during conversion");
  AST_RESERVED: assert property ((s.cfg & ~acc_pkg::ACC_CFG1_WMASK) == 32'h0000_0000) // RULE23
    else $error("reserved config bit set");
  AST_SW_START: assert property (s.fsm == acc_pkg::ACC_ARM &&
    edge_sel == acc_pkg::ACC_EDGE_OFF |=> s.fsm == acc_pkg::ACC_WAKE) // RULE7
    else $error("software start not taken");
  AST_HW_WAIT: assert property (s.fsm == acc_pkg::ACC_ARM && edge_sel != 2'b00 &&
    !trg_hit |=> s.fsm == acc_pkg::ACC_ARM) // RULE24
    else $error("started without trigger edge");
  AST_POWER_OFF: assert property (s.cfg[acc_pkg::ACC_B_AOFF] && s.fsm == acc_pkg::ACC_IDLE
    ##1 s.cfg[acc_pkg::ACC_B_AOFF] && s.fsm == acc_pkg::ACC_IDLE |-> !adc_power_on) // RULE20
    else $error("converter powered while idle");
  AST_WAIT_HOLD: assert property (s.cfg[acc_pkg::ACC_B_WAIT] && s.data_valid &&
    s.fsm == acc_pkg::ACC_WAKE |=> !adc_sample_req) // RULE11
    else $error("sample issued while result unread");
  AST_START_CLR: assert property ($fell(s.start) |-> $past(s.fsm) inside
    {acc_pkg::ACC_CONV, acc_pkg::ACC_WAKE}) // RULE21
    else $error("start cleared outside sequence");
  AST_AWD_GATE: assert property (awd_check |-> $past(s.cfg[acc_pkg::ACC_B_AWD_EN])) // RULE14
    else $error("watchdog check while disabled");
  AST_RST_ZERO: assert property ($past(rst) |-> s.cfg == 32'h0000_0000) // RULE19
    else $error("config not zero after reset");

  COV_SCAN: cover property (adc_sample_req ##[1:50] adc_sample_req);
  COV_OVR: cover property (overrun);
  COV_TRIG: cover property (s.fsm == acc_pkg::ACC_ARM && trg_hit);
  COV_DMA: cover property (dma_req && dma_circular);
endmodule // acc_conv_cfg

/* verif/test_adc_conversion_config.sv */
// self-checking bench for the conversion configuration block
`timescale 1ns/10ps
module test_adc_conversion_config;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  acc_pkg::acc_apb_req_t apb_req = '0;
  logic [7:0] ext_trig = 8'h00;
  logic adc_done = 1'b0;
  logic [11:0] adc_raw = 12'h000;
  logic pready, pslverr, adc_sample_req, adc_power_on, dma_req, dma_circular, awd_check, overrun;
  logic [31:0] prdata, rd;
  logic [4:0] adc_channel;
  logic err;
  int n_fail = 0;
  int tests_run = 0;

  always #2.5 clk_sys = ~clk_sys;

  acc_conv_cfg uut (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .ext_trig(ext_trig), .adc_done(adc_done),
    .adc_raw(adc_raw), .adc_sample_req(adc_sample_req), .adc_channel(adc_channel),
    .adc_power_on(adc_power_on), .dma_req(dma_req), .dma_circular(dma_circular),
    .awd_check(awd_check), .overrun(overrun));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic timeout();
    n_fail++;
    $display("mismatch at %0t: wait ran out", $time);
    end_of_test();
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk_sys);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.paddr <= {20'h0_0000, a};
    apb_req.pwrite <= wr;
    apb_req.pwdata <= wd;
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 20) timeout();
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  // wait for a sample request, answer it, then look at the result pulses
  task automatic sample(input logic [4:0] ch, input logic [11:0] raw, input logic [2:0] exp,
                        input logic [2:0] m);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (adc_sample_req === 1'b1) break;
    end
    if (i == 40) timeout();
    check(32'(adc_channel), 32'(ch));
    check(32'(adc_power_on), 32'h0000_0001);
    adc_done <= 1'b1;
    adc_raw <= raw;
    @(posedge clk_sys);
    adc_done <= 1'b0;
    @(posedge clk_sys);
    check(32'({dma_req, overrun, awd_check} & m), 32'(exp & m));
  endtask

  task automatic idle();
    int i;
    for (i = 0; i < 20; i++) begin
      apb(1'b0, 12'h008, 32'h0000_0000);
      if (rd[2] === 1'b0) break;
    end
    check(32'(rd[2]), 32'h0000_0000);
  endtask

  task automatic go(input logic [31:0] cfg, input logic [17:0] chm);
    apb(1'b1, 12'h028, {14'h0000, chm});
    apb(1'b1, 12'h00C, cfg);
    apb(1'b1, 12'h008, 32'h0000_0004);
  endtask

  initial begin
    int i;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check(rd, 32'h7CC1_FDFF);
    repeat (3) @(posedge clk_sys);
    check(32'(dma_circular), 32'h0000_0001);
    apb(1'b1, 12'h00C, 32'h0000_8002);
    repeat (3) @(posedge clk_sys);
    check(32'({dma_circular, adc_power_on}), 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000);
    check({rd[30:0], err}, 32'h0000_0001);
    // resolution codes, watchdog on all channels for odd codes
    for (i = 0; i < 4; i++) begin
      go(32'(i) << 3 | 32'(i & 1) << 23, 18'h0_0001);
      sample(5'h00, 12'hABC, {2'b00, 1'(i)}, 3'b101);
      apb(1'b0, 12'h040, 32'h0000_0000);
      check(rd, 32'h0000_0ABC >> (2 * i));
      idle();
    end
    // left alignment with a single watchdog channel
    for (i = 0; i < 2; i++) begin
      go(32'h00C0_0020 | 32'(i) << 28, 18'h0_0011);
      sample(5'h00, 12'hABC, {2'b00, ~1'(i)}, 3'b001);
      sample(5'h04, 12'hABC, {2'b00, 1'(i)}, 3'b001);
      apb(1'b0, 12'h040, 32'h0000_0000);
      check(rd, 32'h0000_ABC0);
      idle();
    end
    // scan direction and overrun handling
    for (i = 0; i < 2; i++) begin
      go(32'h0000_0001 | 32'(i) << 2 | 32'(i) << 12, 18'h0_000A);
      sample(5'(i ? 3 : 1), 12'h111, 3'b100, 3'b110);
      sample(5'(i ? 1 : 3), 12'h222, 3'b010, 3'b010);
      apb(1'b0, 12'h040, 32'h0000_0000);
      check(rd, i ? 32'h0000_0222 : 32'h0000_0111);
      idle();
    end
    // hardware trigger edges: rising, falling, both
    for (i = 1; i < 4; i++) begin
      go(32'(i) << 10 | 32'(2 * i + 1) << 6, 18'h0_0004);
      if (i == 1) begin
        apb(1'b1, 12'h00C, 32'h0000_0000);
      end
      repeat (8) begin
        @(posedge clk_sys);
        check(32'(adc_sample_req), 32'h0000_0000);
      end
      ext_trig <= ~ext_trig;
      sample(5'h02, 12'h333, 3'b000, 3'b111);
      apb(1'b0, 12'h040, 32'h0000_0000);
      check(rd, 32'h0000_0333);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      check(rd, 32'(i) << 10 | 32'(2 * i + 1) << 6);
      idle();
    end
    // discontinuous with auto-off: one channel per trigger edge
    go(32'h0001_8C00, 18'h0_0003);
    for (i = 0; i < 2; i++) begin
      repeat (8) begin
        @(posedge clk_sys);
        check(32'({adc_sample_req, adc_power_on}), 32'h0000_0000);
      end
      ext_trig <= ~ext_trig;
      sample(5'(i), 12'h666, 3'b000, 3'b100);
    end
    apb(1'b0, 12'h040, 32'h0000_0000);
    check(rd, 32'h0000_0666);
    idle();
    // continuous with wait: next sample only after the result is read
    go(32'h0000_6000, 18'h0_0001);
    sample(5'h00, 12'h444, 3'b000, 3'b100);
    repeat (8) begin
      @(posedge clk_sys);
      check(32'(adc_sample_req), 32'h0000_0000);
    end
    apb(1'b0, 12'h040, 32'h0000_0000);
    check(rd, 32'h0000_0444);
    sample(5'h00, 12'h555, 3'b000, 3'b010);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check(32'(rd[2]), 32'h0000_0001);
    // reset in mid-run ends the continuous sequence
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    end_of_test();
  end
endmodule // test_adc_conversion_config
